// file: design/ssw_pkg.sv
// supply supervisor package: timing constants and state encoding
// assumes a single free running core clock at CORE_CLK_MHZ
//
// What this block does
// - Reset stays asserted for as long as the undervoltage indication is active.
// - After every reset source clears, reset stays asserted for the full reset_hold_period.
// - With the dual option the active-high output is always the complement of the active-low one.
// - With the manual option, reset is asserted while the filtered manual_reset_n is low.
// - An unconnected manual_reset_n counts as high and never causes a reset.
// - manual_reset_n is debounced and low pulses up to about 100 ns are ignored.
// - With the watchdog option, each rising or falling strobe edge clears the timer; 50 ns pulses count.
// - A full watchdog_period without a clearing event asserts reset, followed by the hold period.
// - Undervoltage or manual reset also clear the watchdog timer.
// - While reset is asserted the watchdog timer stays cleared and restarts only after release.
// - A floating or three-stated strobe disconnects the watchdog so a timeout cannot reset.
`default_nettype none
package ssw_pkg;
    // ==================================================
    // clock and times
    localparam int CORE_CLK_MHZ = 250;
    localparam int WD_PERIOD_MS = 1600;
    localparam int HOLD_PERIOD_MS = 140;
    localparam int MAN_GLITCH_NS = 100;
    localparam int MAN_PULSE_NS = 1000;
    localparam int WD_PULSE_NS = 50;
    // ==================================================
    // derived cycle counts (least times round up, longest down)
    localparam int WD_PERIOD_CYC = WD_PERIOD_MS * CORE_CLK_MHZ * 1000;
    localparam int HOLD_PERIOD_CYC = HOLD_PERIOD_MS * CORE_CLK_MHZ * 1000;
    localparam int MAN_GLITCH_CYC = (MAN_GLITCH_NS * CORE_CLK_MHZ) / 1000;
    localparam int MAN_FILTER_LEN = MAN_GLITCH_CYC + 1;
    localparam int MAN_PULSE_CYC = (MAN_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
    localparam int WD_PULSE_CYC = (WD_PULSE_NS * CORE_CLK_MHZ + 999) / 1000;
    // ==================================================
    // reset values of the synchronisers
    localparam logic SYNC_UV_RST = 1'h1;
    localparam logic SYNC_MAN_RST = 1'h1;
    localparam logic SYNC_WD_RST = 1'h0;
    localparam logic SYNC_FLOAT_RST = 1'h1;
    // ==================================================
    // supervisor states
    typedef enum logic [2:0]
    {
        SSW_ASSERT = 3'h1,
        SSW_HOLD = 3'h2,
        SSW_RUN = 3'h4
    } ssw_state_e;
endpackage
`default_nettype wire

// file: design/ssw_filt_if.sv
// interface between the supervisor and its input filter
// assumes both ends run on core_clk_i
`timescale 1ns/1ps
`default_nettype none
interface ssw_filt_if;
    logic raw;
    logic filtered;
    // ==================================================
    // filter side takes the raw level and returns the clean one
    modport filt (input raw, output filtered);
    modport user (output raw, input filtered);
endinterface
`default_nettype wire

// file: design/ssw_filter.sv
// debounce and glitch filter for a synchronised level
// assumes raw already passed two flip-flops on core_clk_i
`timescale 1ns/1ps
`default_nettype none
module ssw_filter
    import ssw_pkg::*;
#(
    parameter int LEN = MAN_FILTER_LEN,
    parameter logic RST_LEVEL = 1'h1
)
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    ssw_filt_if.filt port_f
);
    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] CNT_LAST = CW'(LEN - 1);
    logic level;
    logic next_level;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    // ==================================================
    // level flips only after LEN differing samples in a row
    always_comb
    begin
        next_level = level;
        next_cnt = '0;
        if (port_f.raw != level)
        begin
            if (cnt == CNT_LAST)
            begin
                next_level = port_f.raw;
            end
            else
            begin
                next_cnt = cnt + CW'(1);
            end
        end
    end
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            level <= RST_LEVEL;
            cnt <= '0;
        end
        else
        begin
            level <= next_level;
            cnt <= next_cnt;
        end
    end
    assign port_f.filtered = level;
    // ==================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence short_run_s;
        (port_f.raw != level) && (cnt != CNT_LAST);
    endsequence
    filt_flip_a: assert property ($changed(level) |-> $past(cnt) == CNT_LAST)
        else $error("filter changed before its full run");
    filt_hold_a: assert property (short_run_s |=> $stable(level))
        else $error("filter passed a short pulse");
endmodule // ssw_filter
`default_nettype wire

// file: design/ssw_top.sv
// supply supervisor with manual reset and watchdog
// assumes undervoltage, manual reset, strobe and strobe-float level arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
module ssw_top
    import ssw_pkg::*;
#(
    parameter bit MANUAL_EN = 1'b1,
    parameter bit WATCHDOG_EN = 1'b1,
    parameter bit DUAL_EN = 1'b1,
    parameter int WD_CYC = WD_PERIOD_CYC,
    parameter int HOLD_CYC = HOLD_PERIOD_CYC,
    parameter int FILTER_LEN = MAN_FILTER_LEN
)
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic undervolt_i,
    input wire logic manual_reset_n_i,
    input wire logic watchdog_strobe_in_i,
    input wire logic watchdog_strobe_float_i,
    output logic reset_n_o,
    output logic reset_o,
    output logic wd_timeout_o
);
    // ==================================================
    // widths and limits
    localparam int WW = $clog2(WD_CYC + 1);
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam logic [WW-1:0] WD_LAST = WW'(WD_CYC - 1);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYC - 1);

    // ==================================================
    // input synchronisers
    logic uv_meta;
    logic uv_sync;
    logic man_meta;
    logic man_sync;
    logic wd_meta;
    logic wd_sync;
    logic fl_meta;
    logic fl_sync;
    logic next_uv_meta;
    logic next_man_meta;
    logic next_wd_meta;
    logic next_fl_meta;

    // first stage feeds only the second stage
    always_comb
    begin
        next_uv_meta = undervolt_i;
        next_man_meta = manual_reset_n_i;
        next_wd_meta = watchdog_strobe_in_i;
        next_fl_meta = watchdog_strobe_float_i;
    end

    // two flip-flops on every outside level
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            uv_meta <= SYNC_UV_RST;
            uv_sync <= SYNC_UV_RST;
            man_meta <= SYNC_MAN_RST;
            man_sync <= SYNC_MAN_RST;
            wd_meta <= SYNC_WD_RST;
            wd_sync <= SYNC_WD_RST;
            fl_meta <= SYNC_FLOAT_RST;
            fl_sync <= SYNC_FLOAT_RST;
        end
        else
        begin
            uv_meta <= next_uv_meta;
            uv_sync <= uv_meta;
            man_meta <= next_man_meta;
            man_sync <= man_meta;
            wd_meta <= next_wd_meta;
            wd_sync <= wd_meta;
            fl_meta <= next_fl_meta;
            fl_sync <= fl_meta;
        end
    end

    // ==================================================
    // manual reset filter
    ssw_filt_if man_if ();
    logic man_clean_n;

    assign man_if.raw = man_sync;

    ssw_filter #(
        .LEN(FILTER_LEN),
        .RST_LEVEL(SYNC_MAN_RST)
    ) u_man_filter (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .port_f(man_if.filt)
    );

    // an absent option reads as a released button
    assign man_clean_n = MANUAL_EN ? man_if.filtered : 1'b1;

    // ==================================================
    // reset sources
    logic src_active;
    logic wd_edge;
    logic wd_live;
    logic wd_expire;
    logic wd_prev;
    logic next_wd_prev;

    // level sources keep reset asserted while present
    assign src_active = uv_sync || !man_clean_n;
    // strobe edge in either direction
    assign wd_edge = wd_sync ^ wd_prev;
    // watchdog counts only when built and driven
    assign wd_live = WATCHDOG_EN && !fl_sync;

    // ==================================================
    // supervisor state machine
    ssw_state_e state;
    ssw_state_e next_state;
    logic [HW-1:0] hold_cnt;
    logic [HW-1:0] next_hold_cnt;
    logic [WW-1:0] wd_cnt;
    logic [WW-1:0] next_wd_cnt;
    logic rst_q;
    logic next_rst_q;
    logic expire_q;
    logic next_expire_q;

    // timeout fires when the timer runs a full period undisturbed
    assign wd_expire = (state == SSW_RUN) && wd_live && !wd_edge && (wd_cnt == WD_LAST);

    // next state, hold count and watchdog count
    always_comb
    begin
        next_state = state;
        next_hold_cnt = '0;
        case (state)
            SSW_ASSERT:
            begin
                if (!src_active)
                begin
                    next_state = SSW_HOLD;
                end
            end
            SSW_HOLD:
            begin
                if (src_active)
                begin
                    next_state = SSW_ASSERT;
                end
                else if (hold_cnt == HOLD_LAST)
                begin
                    next_state = SSW_RUN;
                end
                else
                begin
                    next_hold_cnt = hold_cnt + HW'(1);
                end
            end
            SSW_RUN:
            begin
                if (src_active)
                begin
                    next_state = SSW_ASSERT;
                end
                else if (wd_expire)
                begin
                    next_state = SSW_HOLD;
                end
            end
            default:
            begin
                next_state = SSW_ASSERT;
            end
        endcase
        // timer stays cleared while reset is out, on any edge and when floating
        // the first cycle of run still shows a cleared timer, so a period is WD_CYC cycles
        if (state != SSW_RUN || next_state != SSW_RUN || wd_edge || !wd_live)
        begin
            next_wd_cnt = '0;
        end
        else if (wd_cnt == WD_LAST)
        begin
            next_wd_cnt = wd_cnt;
        end
        else
        begin
            next_wd_cnt = wd_cnt + WW'(1);
        end
        next_rst_q = (next_state != SSW_RUN);
        next_expire_q = wd_expire;
        next_wd_prev = wd_sync;
    end

    // registers of the state machine
    always_ff @(posedge core_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state <= SSW_ASSERT;
            hold_cnt <= '0;
            wd_cnt <= '0;
            rst_q <= 1'b1;
            expire_q <= 1'b0;
            wd_prev <= SYNC_WD_RST;
        end
        else
        begin
            state <= next_state;
            hold_cnt <= next_hold_cnt;
            wd_cnt <= next_wd_cnt;
            rst_q <= next_rst_q;
            expire_q <= next_expire_q;
            wd_prev <= next_wd_prev;
        end
    end

    // ==================================================
    // outputs, both reset outputs from the one reset flop, timeout from expire_q
    assign reset_n_o = !rst_q;
    assign reset_o = DUAL_EN ? rst_q : 1'b0;
    assign wd_timeout_o = expire_q;

    // ==================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence hold_end_s;
        (state == SSW_HOLD) && !src_active && (hold_cnt == HOLD_LAST);
    endsequence

    sequence expire_s;
        (state == SSW_RUN) && !src_active && wd_expire;
    endsequence

    uv_asserts_a: assert property (uv_sync |=> !reset_n_o)
        else $error("undervoltage did not hold reset");
    release_after_hold_a: assert property ($rose(reset_n_o)
        |-> $past((state == SSW_HOLD) && (hold_cnt == HOLD_LAST)))
        else $error("reset released before the hold period ended");
    hold_counts_a: assert property ((state == SSW_HOLD) && !src_active && (hold_cnt != HOLD_LAST)
        |=> !reset_n_o && (hold_cnt == $past(hold_cnt) + HW'(1)))
        else $error("hold counter did not advance");
    out_compl_a: assert property (DUAL_EN |-> (reset_o == !reset_n_o))
        else $error("reset outputs are not complements");
    manual_asserts_a: assert property (MANUAL_EN && !man_if.filtered |=> !reset_n_o)
        else $error("manual reset did not assert reset");
    edge_clears_a: assert property (wd_edge |=> wd_cnt == '0)
        else $error("strobe edge did not clear the timer");
    timeout_reset_a: assert property (expire_s |=> !reset_n_o && (state == SSW_HOLD) && (hold_cnt == '0))
        else $error("watchdog timeout did not start the hold period");
    wd_held_a: assert property (!reset_n_o |-> wd_cnt == '0)
        else $error("timer ran while reset asserted");
    float_off_a: assert property (fl_sync |=> (wd_cnt == '0) && !wd_timeout_o)
        else $error("floating strobe still drives the watchdog");

    // ==================================================
    // watchdog timer steps
    sequence run_step_s;
        (state == SSW_RUN) && !src_active && wd_live && !wd_edge && (wd_cnt != WD_LAST);
    endsequence

    sequence full_count_s;
        (state == SSW_RUN) && wd_live && !wd_edge && (wd_cnt == WD_LAST);
    endsequence

    // timer advances by one per quiet cycle in run
    run_counts_a: assert property (run_step_s |=> wd_cnt == $past(wd_cnt) + WW'(1))
        else $error("watchdog timer did not advance");
    // a full count always ends in one timeout pulse
    timeout_pulse_a: assert property (full_count_s |=> wd_timeout_o ##1 !wd_timeout_o)
        else $error("watchdog expiry pulse is wrong");
    // a timeout pulse never follows a short count
    timeout_full_a: assert property ($rose(wd_timeout_o) |-> $past(wd_cnt) == WD_LAST)
        else $error("timeout pulse without a full period");
    // level sources clear the timer
    uv_clears_a: assert property (uv_sync |=> wd_cnt == '0)
        else $error("undervoltage did not clear the timer");
    // manual reset clears it as well
    manual_clears_a: assert property (!man_clean_n |=> wd_cnt == '0)
        else $error("manual reset did not clear the timer");

    // ==================================================
    // hold period steps
    sequence hold_cut_s;
        (state == SSW_HOLD) && src_active;
    endsequence

    // hold ends in run with a fresh timer
    hold_done_a: assert property (hold_end_s
        |=> reset_n_o && (state == SSW_RUN) && (wd_cnt == '0))
        else $error("hold period did not end in run");
    // a source during hold starts over
    hold_restart_a: assert property (hold_cut_s
        |=> (state == SSW_ASSERT) && !reset_n_o && (hold_cnt == '0))
        else $error("source during hold did not restart it");
    // the assert state always shows reset
    assert_shows_a: assert property ((state == SSW_ASSERT) |-> !reset_n_o)
        else $error("assert state without reset output");
endmodule // ssw_top
`default_nettype wire

// file: verification/ssw_cpu_model.sv
// processor model: drives the watchdog strobe and the strobe float flag
// assumes bench sets the mode inputs and feeds back the supervisor's reset
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic run_i,
    input wire logic float_i,
    input wire logic [15:0] high_cyc_i,
    input wire logic [15:0] low_cyc_i,
    output logic strobe_o,
    output logic float_o
);
    // ==================================================
    // strobe pattern
    logic [15:0] cnt;
    initial
    begin
        strobe_o = 1'b0;
        float_o = 1'b0;
        cnt = 16'h0;
    end
    // released pin wanders every cycle, held low while in reset
    always @(posedge core_clk_i)
    begin
        float_o <= #1 float_i;
        if (float_i)
        begin
            strobe_o <= #1 ~strobe_o;
            cnt <= 16'h0;
        end
        else if (!run_i || !rst_n_i)
        begin
            strobe_o <= #1 1'b0;
            cnt <= 16'h0;
        end
        else if (cnt >= (strobe_o ? high_cyc_i : low_cyc_i) - 16'h1)
        begin
            strobe_o <= #1 ~strobe_o;
            cnt <= 16'h0;
        end
        else
            cnt <= cnt + 16'h1;
    end
endmodule // ssw_cpu_model
`default_nettype wire

// file: verification/supply_supervisor_watchdog_reset_tb.sv
// self-checking bench for the supply supervisor top
// assumes short periods WD and HOLD given to the design by parameter
`timescale 1ns/1ps
`default_nettype none
module supply_supervisor_watchdog_reset_tb;
    import ssw_pkg::*;
    localparam int WD = 200;
    localparam int HOLD = 50;
    logic core_clk_i, reset_n_i, undervolt_i, manual_reset_n_i, run, flt;
    logic [15:0] hi, lo;
    logic strobe, strobe_float, reset_n_o, reset_o, wd_timeout_o;
    int failures, comparisons, pulses, n, p;
    // ==================================================
    // design and processor model
    ssw_top #(.WD_CYC(WD), .HOLD_CYC(HOLD)) i_dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .undervolt_i(undervolt_i), .manual_reset_n_i(manual_reset_n_i), .watchdog_strobe_in_i(strobe),
        .watchdog_strobe_float_i(strobe_float), .reset_n_o(reset_n_o), .reset_o(reset_o),
        .wd_timeout_o(wd_timeout_o));
    ssw_cpu_model i_cpu (.core_clk_i(core_clk_i), .rst_n_i(reset_n_o), .run_i(run), .float_i(flt),
        .high_cyc_i(hi), .low_cyc_i(lo), .strobe_o(strobe), .float_o(strobe_float));
    // clock
    initial
    begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    // ==================================================
    // helpers
    task automatic tally_and_finish();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok)
        begin
            failures++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask
    task automatic cycles(input int k);
        repeat (k) @(posedge core_clk_i);
        #1;
    endtask
    // count cycles until reset_n_o shows val, bounded
    task automatic wait_rst(input logic val, input int limit, output int k);
        k = 0;
        while (reset_n_o !== val)
        begin
            cycles(1);
            k++;
            if (k > limit)
            begin
                check(0, "reset output did not change");
                tally_and_finish();
            end
        end
    endtask
    task automatic stay_high(input int k, input string msg);
        bit ok;
        ok = 1;
        repeat (k)
        begin
            cycles(1);
            if (reset_n_o !== 1'b1)
                ok = 0;
        end
        check(ok, msg);
    endtask
    // outputs complementary, timeout pulses counted
    always @(negedge core_clk_i)
    begin
        check(reset_o === ~reset_n_o, "outputs not complementary");
        if (wd_timeout_o === 1'b1)
            pulses++;
    end
    // ==================================================
    // scenarios
    task automatic power_up();
        cycles(5);
        reset_n_i = 1'b1;
        wait_rst(1'b1, HOLD + 20, n);
        check(n >= HOLD && n <= HOLD + 6, "power-up hold length");
    endtask
    task automatic strobing();
        run = 1'b1;
        hi = 16'd13;
        lo = 16'd190;
        stay_high(1200, "short pulses missed");
        hi = 16'd120;
        lo = 16'd120;
        stay_high(1200, "level strobing missed");
    endtask
    task automatic glitch();
        manual_reset_n_i = 1'b0;
        cycles(25);
        manual_reset_n_i = 1'b1;
        stay_high(80, "glitch caused reset");
    endtask
    task automatic undervolt_then_timeout();
        undervolt_i = 1'b1;
        wait_rst(1'b0, 8, n);
        check(n <= 4, "undervoltage reset late");
        cycles(300);
        check(reset_n_o === 1'b0, "reset left during undervoltage");
        run = 1'b0;
        undervolt_i = 1'b0;
        wait_rst(1'b1, HOLD + 10, n);
        check(n >= HOLD + 2 && n <= HOLD + 6, "hold after undervoltage");
        p = pulses;
        wait_rst(1'b0, WD + 10, n);
        check(n >= WD && n <= WD + 3, "watchdog period");
        cycles(3);
        check(pulses == p + 1, "timeout pulse count");
        wait_rst(1'b1, HOLD + 10, n);
        check(n >= HOLD - 4 && n <= HOLD + 3, "hold after timeout");
    endtask
    task automatic manual();
        run = 1'b1;
        manual_reset_n_i = 1'b0;
        wait_rst(1'b0, 40, n);
        check(n >= 26 && n <= 32, "manual reset latency");
        cycles(250);
        check(reset_n_o === 1'b0, "reset left during manual");
        manual_reset_n_i = 1'b1;
        wait_rst(1'b1, HOLD + 40, n);
        check(n >= HOLD + 26 && n <= HOLD + 34, "hold after manual");
    endtask
    task automatic floating();
        run = 1'b0;
        flt = 1'b1;
        p = pulses;
        stay_high(3 * WD, "floating strobe reset");
        check(pulses == p, "timeout while floating");
        flt = 1'b0;
        wait_rst(1'b0, WD + 20, n);
        check(n >= WD - 5, "watchdog not reconnected");
    endtask
    // ==================================================
    // main sequence
    initial
    begin
        failures = 0;
        comparisons = 0;
        pulses = 0;
        reset_n_i = 1'b0;
        undervolt_i = 1'b0;
        manual_reset_n_i = 1'b1;
        run = 1'b0;
        flt = 1'b0;
        hi = 16'd13;
        lo = 16'd100;
        power_up();
        strobing();
        glitch();
        undervolt_then_timeout();
        manual();
        floating();
        tally_and_finish();
    end
endmodule // supply_supervisor_watchdog_reset_tb
`default_nettype wire
